/* verilog/csfs_switch.sv */
// Contract
// - store-and-forward buffers a whole frame and queues it before sending any byte
// - queued frames leave highest priority first
// - a frame goes only to the port that reaches its destination node
// - cut-through forwards as soon as destination and port are resolved
// - cut-through latency is fixed and independent of frame length
// - busy outgoing link makes a cut-through frame buffered and queued by priority
// - every cycle has exactly three consecutive ranges
// - only isochronous frames in the iso range, its length in send-clock steps
// - cyclic real-time frames carry priority 6 and go first in their range
// - priority values 1 to 7 are accepted
// - standard traffic only in the remaining interval
// - real-time and standard traffic stay out of the reserved iso bandwidth
// - cyclic real-time update periods are at least 250 us
// - iso update periods down to 125 us, send-clock jitter under 1 us
// - slaves align their cycle to the sync master clock
// - the device can act as sync master or as sync slave
// - losing the sync master fails the isochronous exchange
// - iso frames leave at planned instants of the cycle
`timescale 1ns/100ps
module csfs_switch #(
	parameter int NPORT       = 4,
	parameter int NODES       = 16,
	parameter int NSLOT       = 4,
	parameter int MAXLEN      = 64,
	parameter int CW          = csfs_pkg::CW,
	parameter int PCC_MIN_CYC = csfs_pkg::PCC_MIN_CYC,
	parameter int ISO_MIN_CYC = csfs_pkg::ISO_MIN_CYC,
	localparam int PW         = $clog2(NPORT),
	localparam int SW         = $clog2(NSLOT),
	localparam int LW         = $clog2(MAXLEN) + 1
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     nrst_i,
	input  wire logic                     ce_i,
	input  wire logic                     cut_through_i,
	input  wire logic                     sync_master_i,
	input  wire logic                     sync_pin_i,
	input  wire logic [CW-1:0]            cycle_len_i,
	input  wire logic [csfs_pkg::STW-1:0] iso_steps_i,
	input  wire logic [CW-1:0]            pcc_len_i,
	input  wire logic [CW-1:0]            iso_slot_i,
	input  wire logic [NODES*PW-1:0]      route_map_i,
	input  wire logic                     in_valid_i,
	input  wire csfs_pkg::csfs_beat_s     in_beat_i,
	input  wire csfs_pkg::csfs_hdr_s      in_hdr_i,
	input  wire logic [NPORT-1:0]         link_busy_i,
	output logic                          in_ready_o,
	output logic [NPORT-1:0]              out_valid_o,
	output csfs_pkg::csfs_beat_s          out_beat_o,
	output csfs_pkg::csfs_gate_s          gate_o,
	output logic                          sync_out_o,
	output logic                          iso_fail_o,
	output logic                          drop_o
);
	typedef enum logic [1:0] {IN_IDLE, IN_STORE, IN_CUT, IN_DROP} csfs_in_e;
	typedef enum logic {EG_IDLE, EG_SEND} csfs_eg_e;

	localparam logic [LW-1:0] LAST = LW'(MAXLEN - 1);

	// output port that reaches a node
	function automatic logic [PW-1:0] route(input logic [csfs_pkg::NODE_W-1:0] dst,
	                                        input logic [NODES*PW-1:0] map);
		route = map[dst*PW +: PW];
	endfunction

	// one-hot valid for a port
	function automatic logic [NPORT-1:0] port_dec(input logic [PW-1:0] p);
		port_dec = NPORT'(1) << p;
	endfunction

	// priority 0 is lifted to the lowest accepted value
	function automatic logic [2:0] prio_n(input logic [2:0] p);
		prio_n = (p < csfs_pkg::PRIO_MIN) ? csfs_pkg::PRIO_MIN : p;
	endfunction

	// may a frame of this class start now
	function automatic logic elig(input csfs_pkg::csfs_gate_s g, input logic iso,
	                              input logic [2:0] prio, input logic [CW-1:0] cnt,
	                              input logic [CW-1:0] slot);
		if (iso) begin
			elig = g.iso && cnt >= slot;
		end else begin
			elig = (g.pcc && prio == csfs_pkg::PRIO_PCC) || g.std;
		end
	endfunction

	csfs_in_e             in_st;
	csfs_eg_e             eg_st;
	logic                 sync_m;
	logic                 sync_s;
	logic                 sync_d;
	logic                 sync_rise;
	logic [CW-1:0]        t_cnt;
	csfs_pkg::csfs_gate_s t_gate;
	logic                 t_start;
	logic                 t_fail;
	logic [csfs_pkg::DW-1:0] mem [NSLOT*MAXLEN];
	logic [NSLOT-1:0]     used;
	logic [LW-1:0]        s_len [NSLOT];
	logic [2:0]           s_prio [NSLOT];
	logic [PW-1:0]        s_port [NSLOT];
	logic [NSLOT-1:0]     s_iso;
	logic [SW-1:0]        wslot;
	logic [LW-1:0]        wptr;
	logic [PW-1:0]        c_port;
	logic [SW-1:0]        eg_slot;
	logic [LW-1:0]        rptr;
	logic [PW-1:0]        eg_port;
	logic                 acc;
	logic                 first;
	logic [PW-1:0]        r_port;
	logic [2:0]           h_prio;
	logic                 has_free;
	logic [SW-1:0]        free_idx;
	logic                 cut_go;
	logic                 pick_ok;
	logic [SW-1:0]        pick;
	logic                 eg_go;
	logic                 new_buf;
	logic                 wr_en;
	logic [SW-1:0]        wr_slot;
	logic [LW-1:0]        wr_ptr;
	logic                 commit;
	logic                 better;

	// sync pin passes two flip-flops, then its rising edge is taken
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_m <= 1'b0;
			sync_s <= 1'b0;
			sync_d <= 1'b0;
		end else if (ce_i) begin
			sync_m <= sync_pin_i;
			sync_s <= sync_m;
			sync_d <= sync_s;
		end
	end
	assign sync_rise = sync_s & ~sync_d;

	// cycle counter and range gates
	csfs_cycle_timer #(
		.CW          (CW),
		.PCC_MIN_CYC (PCC_MIN_CYC),
		.ISO_MIN_CYC (ISO_MIN_CYC)
	) u_timer (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.ce_i        (ce_i),
		.master_i    (sync_master_i),
		.sync_i      (sync_rise),
		.cycle_len_i (cycle_len_i),
		.iso_steps_i (iso_steps_i),
		.pcc_len_i   (pcc_len_i),
		.cnt_o       (t_cnt),
		.gate_o      (t_gate),
		.start_o     (t_start),
		.fail_o      (t_fail)
	);

	// master drives its cycle start out, both roles report range and sync state
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_out_o <= 1'b0;
			gate_o <= '{iso: 1'b0, pcc: 1'b0, std: 1'b1};
			iso_fail_o <= 1'b0;
		end else if (ce_i) begin
			sync_out_o <= sync_master_i & t_start;
			gate_o <= t_gate;
			iso_fail_o <= t_fail;
		end
	end

	// header decode and free buffer search
	always_comb begin
		acc = in_valid_i & in_ready_o;
		first = acc && in_st == IN_IDLE && in_beat_i.sof;
		r_port = route(in_hdr_i.dst, route_map_i);
		h_prio = prio_n(in_hdr_i.prio);
		has_free = 1'b0;
		free_idx = '0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (!used[i] && !(in_st == IN_STORE && wslot == SW'(i))) begin
				has_free = 1'b1;
				free_idx = SW'(i);
			end
		end
	end

	// cut through only on an idle link with the frame's range open
	assign cut_go = first && cut_through_i && !link_busy_i[r_port] && eg_st == EG_IDLE
		&& elig(t_gate, in_hdr_i.iso, h_prio, t_cnt, iso_slot_i);

	// pick the highest priority queued frame that may start now
	always_comb begin
		pick_ok = 1'b0;
		pick = '0;
		for (int i = 0; i < NSLOT; i++) begin
			if (used[i] && !link_busy_i[s_port[i]]
			    && elig(t_gate, s_iso[i], s_prio[i], t_cnt, iso_slot_i)) begin
				if (!pick_ok || s_prio[i] > s_prio[pick]) begin
					pick_ok = 1'b1;
					pick = SW'(i);
				end
			end
		end
	end
	assign eg_go = eg_st == EG_IDLE && pick_ok && in_st != IN_CUT && !cut_go;

	// buffer write and commit of a complete frame
	assign new_buf = first && !cut_go && has_free;
	assign wr_en = new_buf || (acc && in_st == IN_STORE && wptr <= LAST);
	assign wr_slot = new_buf ? free_idx : wslot;
	assign wr_ptr = new_buf ? '0 : wptr;
	assign commit = wr_en && in_beat_i.eof;

	// ingress frame handling
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_st <= IN_IDLE;
			wslot <= '0;
			wptr <= '0;
			c_port <= '0;
			drop_o <= 1'b0;
		end else if (ce_i) begin
			drop_o <= 1'b0;
			if (acc) begin
				case (in_st)
					IN_IDLE: if (in_beat_i.sof) begin
						c_port <= r_port;
						if (cut_go) begin
							in_st <= in_beat_i.eof ? IN_IDLE : IN_CUT;
						end else if (has_free) begin
							wslot <= free_idx;
							wptr <= LW'(1);
							in_st <= in_beat_i.eof ? IN_IDLE : IN_STORE;
						end else begin
							drop_o <= 1'b1;
							in_st <= in_beat_i.eof ? IN_IDLE : IN_DROP;
						end
					end
					IN_STORE: begin
						wptr <= wptr + 1'b1;
						if (in_beat_i.eof) begin
							in_st <= IN_IDLE;
						end else if (wptr == LAST) begin
							drop_o <= 1'b1;
							in_st <= IN_DROP;
						end
					end
					IN_CUT, IN_DROP: if (in_beat_i.eof) begin
						in_st <= IN_IDLE;
					end
					default: in_st <= IN_IDLE;
				endcase
			end
		end
	end

	// a started frame is always taken to its end, a new one needs a free buffer
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			in_ready_o <= 1'b0;
		end else if (ce_i) begin
			in_ready_o <= in_st != IN_IDLE || has_free;
		end
	end

	// frame buffer memory
	always_ff @(posedge core_clk_i) begin
		if (ce_i && wr_en) begin
			mem[{wr_slot, wr_ptr[LW-2:0]}] <= in_beat_i.data;
		end
	end

	// queue table: set on commit, cleared when the last byte leaves
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			used <= '0;
			s_iso <= '0;
			for (int i = 0; i < NSLOT; i++) begin
				s_len[i] <= '0;
				s_prio[i] <= '0;
				s_port[i] <= '0;
			end
		end else if (ce_i) begin
			if (eg_st == EG_SEND && rptr == s_len[eg_slot] - 1'b1) begin
				used[eg_slot] <= 1'b0;
			end
			if (commit) begin
				used[wr_slot] <= 1'b1;
				s_len[wr_slot] <= wr_ptr + 1'b1;
				s_prio[wr_slot] <= new_buf ? h_prio : s_prio[wr_slot];
				s_port[wr_slot] <= new_buf ? r_port : c_port;
				s_iso[wr_slot] <= new_buf ? in_hdr_i.iso : s_iso[wr_slot];
			end else if (new_buf) begin
				s_prio[wr_slot] <= h_prio;
				s_iso[wr_slot] <= in_hdr_i.iso;
			end
		end
	end

	// egress reader for queued frames
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			eg_st <= EG_IDLE;
			eg_slot <= '0;
			rptr <= '0;
			eg_port <= '0;
		end else if (ce_i) begin
			case (eg_st)
				EG_IDLE: if (eg_go) begin
					eg_slot <= pick;
					eg_port <= s_port[pick];
					rptr <= '0;
					eg_st <= EG_SEND;
				end
				EG_SEND: begin
					rptr <= rptr + 1'b1;
					if (rptr == s_len[eg_slot] - 1'b1) begin
						eg_st <= EG_IDLE;
					end
				end
				default: eg_st <= EG_IDLE;
			endcase
		end
	end

	// output stage: queued bytes or cut-through bytes, one register deep
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_valid_o <= '0;
			out_beat_o <= '0;
		end else if (ce_i) begin
			out_valid_o <= '0;
			if (eg_st == EG_SEND) begin
				out_valid_o <= port_dec(eg_port);
				out_beat_o.sof <= rptr == '0;
				out_beat_o.eof <= rptr == s_len[eg_slot] - 1'b1;
				out_beat_o.data <= mem[{eg_slot, rptr[LW-2:0]}];
			end else if (cut_go || (acc && in_st == IN_CUT)) begin
				out_valid_o <= port_dec(cut_go ? r_port : c_port);
				out_beat_o <= in_beat_i;
			end
		end
	end

	// any eligible queued frame of higher priority than the one picked
	always_comb begin
		better = 1'b0;
		for (int i = 0; i < NSLOT; i++) begin
			if (used[i] && !link_busy_i[s_port[i]] && s_prio[i] > s_prio[pick]
			    && elig(t_gate, s_iso[i], s_prio[i], t_cnt, iso_slot_i)) begin
				better = 1'b1;
			end
		end
	end

	store_first_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go) |-> (used[pick] && !(in_st == IN_STORE && wslot == pick)))
		else $error("frame sent before fully stored");
	prio_pick_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go) |-> !better)
		else $error("lower priority frame sent first");
	one_port_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(|out_valid_o) |-> $onehot(out_valid_o))
		else $error("frame flooded to several ports");
	cut_pass_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && cut_go) |=> (out_valid_o == port_dec($past(r_port)) && out_beat_o == $past(in_beat_i)))
		else $error("cut-through byte not forwarded next cycle");
	cut_delay_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && acc && in_st == IN_CUT) |=> (out_beat_o == $past(in_beat_i) && |out_valid_o))
		else $error("cut-through latency not fixed");
	busy_queue_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && first && link_busy_i[r_port] && has_free) |=> in_st == IN_STORE || $past(in_beat_i.eof))
		else $error("busy link frame not buffered");
	iso_only_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go && t_gate.iso) |-> s_iso[pick])
		else $error("non-iso frame in iso range");
	pcc_prio_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go && t_gate.pcc) |-> (s_prio[pick] == csfs_pkg::PRIO_PCC && !s_iso[pick]))
		else $error("wrong class in real-time range");
	prio_range_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && new_buf) |=> s_prio[$past(free_idx)] >= csfs_pkg::PRIO_MIN)
		else $error("priority outside accepted range");
	std_window_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go && !s_iso[pick] && s_prio[pick] != csfs_pkg::PRIO_PCC) |-> t_gate.std)
		else $error("standard frame outside remaining interval");
	iso_plan_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && eg_go && s_iso[pick]) |-> (t_cnt >= iso_slot_i && t_gate.iso))
		else $error("iso frame off its planned instant");
endmodule

/* common/csfs_pkg.sv */
package csfs_pkg;
	// clock and documented timing figures
	localparam int CLK_NS      = 20;
	localparam int PCC_MIN_US  = 250;
	localparam int ISO_MIN_US  = 125;
	localparam int JIT_MAX_NS  = 1000;
	// least periods round up, the jitter bound rounds down
	localparam int PCC_MIN_CYC = (PCC_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ISO_MIN_CYC = (ISO_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int JIT_CYC     = JIT_MAX_NS / CLK_NS;

	// priority values
	localparam logic [2:0] PRIO_PCC = 3'h6;
	localparam logic [2:0] PRIO_MIN = 3'h1;

	// widths
	localparam int CW         = 16;
	localparam int DW         = 8;
	localparam int NODE_W     = 4;
	localparam int STEP_SHIFT = 4;
	localparam int STW        = STEP_SHIFT + 1;

	// one bit per time range of the cycle
	typedef struct packed {
		logic iso;
		logic pcc;
		logic std;
	} csfs_gate_s;

	// one byte of a frame with its delimiters
	typedef struct packed {
		logic          sof;
		logic          eof;
		logic [DW-1:0] data;
	} csfs_beat_s;

	// frame header, valid with the start beat
	typedef struct packed {
		logic [NODE_W-1:0] dst;
		logic [2:0]        prio;
		logic              iso;
	} csfs_hdr_s;
endpackage

/* verilog/csfs_cycle_timer.sv */
`timescale 1ns/100ps
module csfs_cycle_timer #(
	parameter int CW          = csfs_pkg::CW,
	parameter int PCC_MIN_CYC = csfs_pkg::PCC_MIN_CYC,
	parameter int ISO_MIN_CYC = csfs_pkg::ISO_MIN_CYC
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     nrst_i,
	input  wire logic                     ce_i,
	input  wire logic                     master_i,
	input  wire logic                     sync_i,
	input  wire logic [CW-1:0]            cycle_len_i,
	input  wire logic [csfs_pkg::STW-1:0] iso_steps_i,
	input  wire logic [CW-1:0]            pcc_len_i,
	output logic [CW-1:0]                 cnt_o,
	output csfs_pkg::csfs_gate_s          gate_o,
	output logic                          start_o,
	output logic                          fail_o
);
	localparam logic [CW-1:0] PCC_MIN = CW'(PCC_MIN_CYC);
	localparam logic [CW-1:0] ISO_MIN = CW'(ISO_MIN_CYC);
	localparam logic [CW:0]   JIT     = (CW+1)'(csfs_pkg::JIT_CYC);

	logic [CW-1:0] len;
	logic [CW-1:0] step;
	logic [CW-1:0] iso_end;
	logic [CW-1:0] pcc_end;
	logic [CW:0]   wd;

	// cycle length clamped to the shortest update period, iso range in send-clock steps
	always_comb begin
		len = cycle_len_i;
		if (iso_steps_i != '0 && len < ISO_MIN) begin
			len = ISO_MIN;
		end else if (iso_steps_i == '0 && len < PCC_MIN) begin
			len = PCC_MIN;
		end
		step = len >> csfs_pkg::STEP_SHIFT;
		iso_end = CW'(step * iso_steps_i);
		pcc_end = iso_end + pcc_len_i;
	end

	// master runs free, slave restarts on every sync pulse and flywheels between
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_o <= '0;
			start_o <= 1'b0;
		end else if (ce_i) begin
			start_o <= 1'b0;
			if ((!master_i && sync_i) || cnt_o >= len - 1'b1) begin
				cnt_o <= '0;
				start_o <= 1'b1;
			end else begin
				cnt_o <= cnt_o + 1'b1;
			end
		end
	end

	// three consecutive ranges: iso, cyclic real-time, remaining standard
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			gate_o <= '{iso: 1'b0, pcc: 1'b0, std: 1'b1};
		end else if (ce_i) begin
			gate_o.iso <= cnt_o < iso_end;
			gate_o.pcc <= cnt_o >= iso_end && cnt_o < pcc_end;
			gate_o.std <= cnt_o >= iso_end && cnt_o >= pcc_end;
		end
	end

	// loss of the sync master fails the isochronous exchange until sync returns
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wd <= '0;
			fail_o <= 1'b0;
		end else if (ce_i) begin
			if (master_i || sync_i) begin
				wd <= '0;
				fail_o <= 1'b0;
			end else if (wd > {1'b0, len} + JIT) begin
				fail_o <= iso_steps_i != '0;
			end else begin
				wd <= wd + 1'b1;
			end
		end
	end

	sync_align_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && !master_i && sync_i) |=> (cnt_o == '0 && start_o))
		else $error("slave cycle not realigned to sync");
	loss_fail_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && !master_i && !sync_i && iso_steps_i != '0 && wd > {1'b0, len} + JIT) |=> fail_o)
		else $error("sync loss not flagged");
	range_onehot_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		$onehot(gate_o))
		else $error("time ranges overlap or missing");
	min_period_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(iso_steps_i == '0) |-> len >= PCC_MIN)
		else $error("cyclic period below minimum");
endmodule

/* verification/csfs_peer.sv */
`timescale 1ns/100ps
module csfs_peer (
	input  wire logic                 core_clk_i,
	input  wire logic                 nrst_i,
	input  wire logic [31:0]          now_i,
	input  wire logic [3:0]           busy_req_i,
	input  wire logic [3:0]           out_valid_i,
	input  wire csfs_pkg::csfs_beat_s out_beat_i,
	output logic [3:0]                link_busy_o
);
	// received beats with their port and arrival time
	logic [3:0]           rx_port [$];
	csfs_pkg::csfs_beat_s rx_beat [$];
	logic [31:0]          rx_time [$];

	// links stay busy as long as the bench asks
	assign link_busy_o = busy_req_i;

	// take every beat the switch puts on any link
	always @(posedge core_clk_i) begin
		if (nrst_i && out_valid_i != 4'h0) begin
			rx_port.push_back(out_valid_i);
			rx_beat.push_back(out_beat_i);
			rx_time.push_back(now_i);
		end
	end
endmodule

/* verification/cycle_slot_frame_switch_tb_top.sv */
`timescale 1ns/100ps
module cycle_slot_frame_switch_tb_top;
	logic                 core_clk_i    = 1'b0;
	logic                 nrst_i        = 1'b0;
	logic                 cut_through_i = 1'b0;
	logic                 sync_master_i = 1'b1;
	logic                 sync_pin_i    = 1'b0;
	logic [15:0]          cycle_len_i   = 16'h40;
	logic [4:0]           iso_steps_i   = 5'h0;
	logic [15:0]          pcc_len_i     = 16'h0;
	logic [15:0]          iso_slot_i    = 16'h0;
	logic [31:0]          route_map_i   = 32'he4e4e4e4;
	logic                 in_valid_i    = 1'b0;
	csfs_pkg::csfs_beat_s in_beat_i     = '0;
	csfs_pkg::csfs_hdr_s  in_hdr_i      = '0;
	logic [3:0]           busy_req      = 4'h0;
	logic [3:0]           link_busy;
	logic                 in_ready_o;
	logic [3:0]           out_valid_o;
	csfs_pkg::csfs_beat_s out_beat_o;
	csfs_pkg::csfs_gate_s gate_o;
	logic                 sync_out_o;
	logic                 iso_fail_o;
	logic                 drop_o;
	logic [31:0]          now           = 32'h0;
	logic [31:0]          tk [$];
	int                   miscompares   = 0;
	int                   samples_checked = 0;

	// clock and a free cycle count for latency checks
	always #10 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) now <= now + 32'h1;

	csfs_switch #(.PCC_MIN_CYC(64), .ISO_MIN_CYC(32)) DUT (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .cut_through_i(cut_through_i),
		.sync_master_i(sync_master_i), .sync_pin_i(sync_pin_i), .cycle_len_i(cycle_len_i),
		.iso_steps_i(iso_steps_i), .pcc_len_i(pcc_len_i), .iso_slot_i(iso_slot_i),
		.route_map_i(route_map_i), .in_valid_i(in_valid_i), .in_beat_i(in_beat_i),
		.in_hdr_i(in_hdr_i), .link_busy_i(link_busy), .in_ready_o(in_ready_o),
		.out_valid_o(out_valid_o), .out_beat_o(out_beat_o), .gate_o(gate_o),
		.sync_out_o(sync_out_o), .iso_fail_o(iso_fail_o), .drop_o(drop_o));

	csfs_peer p (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .now_i(now), .busy_req_i(busy_req),
		.out_valid_i(out_valid_o), .out_beat_i(out_beat_o), .link_busy_o(link_busy));

	task automatic end_of_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	// offer one beat and hold it until the switch takes it
	task automatic put(input logic s, input logic e, input logic [7:0] d, input csfs_pkg::csfs_hdr_s h);
		int i;
		in_valid_i <= 1'b1;
		in_beat_i  <= '{sof: s, eof: e, data: d};
		in_hdr_i   <= h;
		for (i = 0; i < 200; i++) begin
			@(posedge core_clk_i);
			if (in_ready_o === 1'b1) break;
		end
		if (i == 200) begin
			miscompares++;
			end_of_test();
		end
		tk.push_back(now);
	endtask

	task automatic frame(input logic [3:0] dst, input logic [2:0] pr, input int n, input logic [7:0] b);
		for (int i = 0; i < n; i++) put(i == 0, i == n - 1, b + 8'(i), '{dst: dst, prio: pr, iso: 1'b0});
		in_valid_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// bounded wait for the peer to hold n beats
	task automatic wait_rx(input int n);
		for (int i = 0; i < 300 && p.rx_beat.size() < n; i++) @(posedge core_clk_i);
		if (p.rx_beat.size() < n) begin
			miscompares++;
			end_of_test();
		end
	endtask

	task automatic clr();
		p.rx_beat.delete();
		p.rx_port.delete();
		p.rx_time.delete();
		tk.delete();
	endtask

	// range lengths over one full cycle: 16 iso, 16 cyclic, 32 std
	task automatic t_gates();
		int ni, nr, ns, bad, ps;
		iso_steps_i <= 5'h4;
		pcc_len_i   <= 16'h10;
		cyc(130);
		repeat (64) begin
			@(posedge core_clk_i);
			#1;
			ni += gate_o.iso;
			nr += gate_o.pcc;
			ns += gate_o.std;
			bad += (32'(gate_o.iso) + gate_o.pcc + gate_o.std != 1);
			ps += sync_out_o;
		end
		@(posedge core_clk_i);
		chk("one hot", bad, 0);
		chk("iso len", ni, 16);
		chk("cyclic len", nr, 16);
		chk("std len", ns, 32);
		chk("sync out", ps, 1);
	endtask

	// cut-through: fixed latency for every beat, on the routed port only
	task automatic t_cut();
		iso_steps_i   <= 5'h0;
		pcc_len_i     <= 16'h0;
		cut_through_i <= 1'b1;
		cyc(140);
		clr();
		frame(4'h5, 3'h1, 4, 8'h30);
		wait_rx(4);
		for (int i = 0; i < 4; i++) begin
			chk("cut lat", p.rx_time[i] - tk[i], 32'h1);
			chk("cut port", p.rx_port[i], 4'h2);
			chk("cut data", p.rx_beat[i].data, 8'h30 + i);
		end
	endtask

	// store-and-forward: nothing leaves while the link is busy, prio 7 before prio 1
	task automatic t_store();
		cut_through_i <= 1'b0;
		busy_req      <= 4'h2;
		clr();
		frame(4'h1, 3'h1, 2, 8'h10);
		frame(4'h5, 3'h7, 3, 8'h20);
		cyc(10);
		chk("held", p.rx_beat.size(), 0);
		busy_req <= 4'h0;
		wait_rx(5);
		chk("first", p.rx_beat[0], 10'h220);
		chk("last", p.rx_beat[4], 10'h111);
		for (int i = 0; i < 5; i++) chk("port", p.rx_port[i], 4'h2);
	endtask

	// busy link turns a cut-through frame into a queued one
	task automatic t_busy();
		cut_through_i <= 1'b1;
		busy_req      <= 4'h2;
		clr();
		frame(4'h9, 3'h1, 2, 8'h40);
		cyc(5);
		chk("busy hold", p.rx_beat.size(), 0);
		busy_req <= 4'h0;
		wait_rx(2);
		chk("busy data", p.rx_beat[1], 10'h141);
	endtask

	// slave without sync fails the iso exchange, the next sync clears it
	task automatic t_sync();
		sync_master_i <= 1'b0;
		iso_steps_i   <= 5'h4;
		cyc(64 + 50 + 20);
		chk("fail set", iso_fail_o, 1'b1);
		sync_pin_i <= 1'b1;
		cyc(4);
		sync_pin_i <= 1'b0;
		cyc(6);
		chk("fail clr", iso_fail_o, 1'b0);
	endtask

	initial begin
		cyc(10);
		#1;
		chk("rst gate", gate_o, 3'h1);
		chk("rst ready", in_ready_o, 1'b0);
		cyc(10);
		nrst_i <= 1'b1;
		t_gates();
		t_cut();
		t_store();
		t_busy();
		t_sync();
		end_of_test();
	end
endmodule
